// file: hlc_pkg.sv
// shared constants of the haptic level calibration register bank
package hlc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_AUDIO_INPUT_THRESHOLD = 8'h12;
  localparam logic [7:0] OFS_AUDIO_INPUT_FULL_SCALE = 8'h13;
  localparam logic [7:0] OFS_AUDIO_DRIVE_FLOOR = 8'h14;
  localparam logic [7:0] OFS_AUDIO_DRIVE_CEILING = 8'h15;
  localparam logic [7:0] OFS_MOTOR_NOMINAL_LEVEL = 8'h16;
  localparam logic [7:0] OFS_BOOST_LIMIT = 8'h17;
  localparam logic [7:0] OFS_CAL_LOSS_COMPENSATION = 8'h18;
  localparam logic [7:0] OFS_CAL_MOTION_FEEDBACK_LEVEL = 8'h19;
  localparam int REG_COUNT = 8;
  // index of each register within the bank
  localparam int IDX_THR = 0;
  localparam int IDX_FS = 1;
  localparam int IDX_FLOOR = 2;
  localparam int IDX_CEIL = 3;
  localparam int IDX_NOM = 4;
  localparam int IDX_BOOST = 5;
  localparam int IDX_COMP = 6;
  localparam int IDX_FB = 7;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_AUDIO_INPUT_THRESHOLD = 8'h19;
  localparam logic [7:0] RST_AUDIO_INPUT_FULL_SCALE = 8'hFF;
  localparam logic [7:0] RST_AUDIO_DRIVE_FLOOR = 8'h19;
  localparam logic [7:0] RST_AUDIO_DRIVE_CEILING = 8'hFF;
  localparam logic [7:0] RST_MOTOR_NOMINAL_LEVEL = 8'h3E;
  localparam logic [7:0] RST_BOOST_LIMIT = 8'h8C;
  localparam logic [7:0] RST_CAL_LOSS_COMPENSATION = 8'h0C;
  localparam logic [7:0] RST_CAL_MOTION_FEEDBACK_LEVEL = 8'h6F;
  localparam logic [REG_COUNT*8-1:0] RST_ALL = {RST_CAL_MOTION_FEEDBACK_LEVEL, RST_CAL_LOSS_COMPENSATION,
                                               RST_BOOST_LIMIT, RST_MOTOR_NOMINAL_LEVEL,
                                               RST_AUDIO_DRIVE_CEILING, RST_AUDIO_DRIVE_FLOOR,
                                               RST_AUDIO_INPUT_FULL_SCALE, RST_AUDIO_INPUT_THRESHOLD};
  // ****************************************
  // codes and scales
  // ****************************************
  localparam logic [8:0] CODE_FULL = 9'h0FF;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// file: hlc_reg_cell.sv
// one eight-bit host and calibration writable register
`timescale 1ns/1ns
`default_nettype none
module hlc_reg_cell #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_host_we,
  input wire logic [7:0] i_host_data,
  input wire logic i_hw_we,
  input wire logic [7:0] i_hw_data,
  output logic [7:0] o_q
);
  typedef struct packed {
    logic [7:0] q;
  } hlc_cell_s;

  hlc_cell_s state_reg;
  hlc_cell_s state_next;

  always_comb begin
    state_next = state_reg;
    // calibration store wins over a host write
    if (i_hw_we) begin
      state_next.q = i_hw_data;
    end else if (i_host_we) begin
      state_next.q = i_host_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg.q <= RESET_VALUE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_q = state_reg.q;
endmodule
`default_nettype wire

// file: hlc_level_regs.sv
// haptic level calibration registers with two-wire serial slave and level outputs
`timescale 1ns/1ns
`default_nettype none
// Operation
// - the audio full-scale input code scales linearly as code times 1.8 V over 255, resetting to all ones.
// - the drive floor code is the lowest level fed to the drive engine, code over 255 of full scale.
// - the drive ceiling code is the highest level fed to the drive engine, code over 255 of full scale; a floor set above it is fed instead.
// - in closed loop the motor nominal level is the full-scale reference, resetting to 0x3E.
// - in open loop the motor nominal level is ignored as reference.
// - closed-loop overdrive and braking may exceed nominal but stay bounded by the boost limit, reset 0x8C.
// - in open loop the boost limit is the full-scale reference.
// - calibration stores the loss compensation result, reset 0x0C, still host writable.
// - playback gain is multiplied by one plus the compensation code over 255.
// - calibration stores the motion-feedback level at nominal drive, code over 255 times 1.22 V over sense gain.
// - the closed-loop feedback gain is derived from the stored motion-feedback result.
// - audio levels below the audio input threshold are ignored.
module hlc_level_regs #(
  parameter logic [6:0] DEV_ADDR = hlc_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_closed_loop,
  input wire logic i_overdrive,
  input wire logic [7:0] i_drive_request,
  input wire logic [7:0] i_audio_level,
  input wire logic i_cal_store,
  input wire logic [7:0] i_cal_comp,
  input wire logic [7:0] i_cal_feedback,
  output logic [7:0] o_full_scale_ref,
  output logic [7:0] o_drive_out,
  output logic [7:0] o_audio_drive,
  output logic o_audio_active,
  output logic [8:0] o_comp_coeff,
  output logic [7:0] o_cal_nominal,
  output logic [7:0] o_fb_level,
  output logic [7:0] o_audio_full_scale
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    HLC_IDLE,
    HLC_ADDR,
    HLC_AACK,
    HLC_WR,
    HLC_WACK,
    HLC_RD,
    HLC_RACK
  } hlc_bus_e;

  typedef struct packed {
    hlc_bus_e st;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic ptr_phase;
    logic master_ack;
    logic [7:0] ptr;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic sda_o;
    logic sda_oe;
    logic [7:0] full_scale_ref;
    logic [7:0] drive_out;
    logic [7:0] audio_drive;
    logic audio_active;
    logic [8:0] comp_coeff;
    logic [7:0] cal_nominal;
    logic [7:0] fb_level;
    logic [7:0] audio_full_scale;
  } hlc_state_s;

  hlc_state_s state_reg;
  hlc_state_s state_next;
  logic [7:0] regs [hlc_pkg::REG_COUNT];

  // ****************************************
  // register bank
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < hlc_pkg::REG_COUNT; gi++) begin : g_reg
      logic cal_we;
      logic [7:0] cal_data;
      assign cal_we = i_cal_store && (gi == hlc_pkg::IDX_COMP || gi == hlc_pkg::IDX_FB);
      assign cal_data = (gi == hlc_pkg::IDX_COMP) ? i_cal_comp : i_cal_feedback;
      hlc_reg_cell #(
        .RESET_VALUE(hlc_pkg::RST_ALL[gi*8 +: 8])
      ) u_cell (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_host_we(state_reg.wr_stb &&
                   state_reg.wr_addr == hlc_pkg::OFS_AUDIO_INPUT_THRESHOLD + 8'(gi)),
        .i_host_data(state_reg.wr_data),
        .i_hw_we(cal_we),
        .i_hw_data(cal_data),
        .o_q(regs[gi])
      );
    end
  endgenerate

  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] idx;
    idx = addr - hlc_pkg::OFS_AUDIO_INPUT_THRESHOLD;
    if (addr >= hlc_pkg::OFS_AUDIO_INPUT_THRESHOLD && addr <= hlc_pkg::OFS_CAL_MOTION_FEEDBACK_LEVEL) begin
      read_reg = regs[idx[2:0]];
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  // ****************************************
  // serial slave and level logic
  // ****************************************
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_byte;
  logic [7:0] thr;
  logic [7:0] fs;
  logic [7:0] floor_lvl;
  logic [7:0] ceil_lvl;
  logic [7:0] nom;
  logic [7:0] boost;
  logic [7:0] limit;
  logic [7:0] mid;

  always_comb begin
    state_next = state_reg;
    state_next.scl_q = i_scl;
    state_next.sda_q = i_sda;
    state_next.wr_stb = 1'b0;
    scl_rise = !state_reg.scl_q && i_scl;
    scl_fall = state_reg.scl_q && !i_scl;
    start_cond = state_reg.scl_q && i_scl && state_reg.sda_q && !i_sda;
    stop_cond = state_reg.scl_q && i_scl && !state_reg.sda_q && i_sda;
    rd_byte = read_reg(state_reg.ptr);
    thr = regs[hlc_pkg::IDX_THR];
    fs = regs[hlc_pkg::IDX_FS];
    floor_lvl = regs[hlc_pkg::IDX_FLOOR];
    ceil_lvl = regs[hlc_pkg::IDX_CEIL];
    nom = regs[hlc_pkg::IDX_NOM];
    boost = regs[hlc_pkg::IDX_BOOST];
    mid = i_audio_level;
    limit = boost;

    if (start_cond) begin
      state_next.st = HLC_ADDR;
      state_next.cnt = 4'h0;
      state_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      state_next.st = HLC_IDLE;
      state_next.sda_oe = 1'b0;
    end else begin
      case (state_reg.st)
        HLC_IDLE: begin
          state_next.sda_oe = 1'b0;
        end
        HLC_ADDR, HLC_WR: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], i_sda};
            state_next.cnt = state_reg.cnt + 4'h1;
          end else if (scl_fall && state_reg.cnt == hlc_pkg::BITS_PER_BYTE) begin
            state_next.cnt = 4'h0;
            if (state_reg.st == HLC_ADDR) begin
              if (state_reg.shift[7:1] == DEV_ADDR) begin
                state_next.rw = state_reg.shift[0];
                state_next.sda_oe = 1'b1;
                state_next.st = HLC_AACK;
              end else begin
                state_next.st = HLC_IDLE;
              end
            end else begin
              if (state_reg.ptr_phase) begin
                state_next.ptr = state_reg.shift;
                state_next.ptr_phase = 1'b0;
              end else begin
                state_next.wr_stb = 1'b1;
                state_next.wr_addr = state_reg.ptr;
                state_next.wr_data = state_reg.shift;
                state_next.ptr = state_reg.ptr + 8'h01;
              end
              state_next.sda_oe = 1'b1;
              state_next.st = HLC_WACK;
            end
          end
        end
        HLC_AACK: begin
          if (scl_fall) begin
            state_next.cnt = 4'h0;
            if (state_reg.rw) begin
              state_next.shift = rd_byte;
              state_next.sda_oe = !rd_byte[7];
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.st = HLC_RD;
            end else begin
              state_next.sda_oe = 1'b0;
              state_next.ptr_phase = 1'b1;
              state_next.st = HLC_WR;
            end
          end
        end
        HLC_WACK: begin
          if (scl_fall) begin
            state_next.sda_oe = 1'b0;
            state_next.st = HLC_WR;
          end
        end
        HLC_RD: begin
          if (scl_rise) begin
            state_next.cnt = state_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (state_reg.cnt == hlc_pkg::BITS_PER_BYTE) begin
              state_next.sda_oe = 1'b0;
              state_next.st = HLC_RACK;
            end else begin
              state_next.shift = {state_reg.shift[6:0], 1'b0};
              state_next.sda_oe = !state_reg.shift[6];
            end
          end
        end
        HLC_RACK: begin
          if (scl_rise) begin
            state_next.master_ack = !i_sda;
          end else if (scl_fall) begin
            state_next.cnt = 4'h0;
            if (state_reg.master_ack) begin
              state_next.shift = rd_byte;
              state_next.sda_oe = !rd_byte[7];
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.st = HLC_RD;
            end else begin
              state_next.st = HLC_IDLE;
            end
          end
        end
        default: begin
          state_next.st = HLC_IDLE;
          state_next.sda_oe = 1'b0;
        end
      endcase
    end

    state_next.full_scale_ref = i_closed_loop ? nom : boost;
    if (i_closed_loop && !i_overdrive) begin
      limit = nom;
    end
    state_next.drive_out = (i_drive_request > limit) ? limit : i_drive_request;

    if (mid > fs) begin
      mid = fs;
    end
    if (mid > ceil_lvl || mid == fs) begin
      mid = ceil_lvl;
    end
    if (mid < floor_lvl) begin
      mid = floor_lvl;
    end
    state_next.audio_active = i_audio_level >= thr;
    state_next.audio_drive = (i_audio_level >= thr) ? mid : 8'h00;
    state_next.audio_full_scale = fs;

    state_next.comp_coeff = hlc_pkg::CODE_FULL + {1'b0, regs[hlc_pkg::IDX_COMP]};
    state_next.cal_nominal = nom;
    state_next.fb_level = regs[hlc_pkg::IDX_FB];
    state_next.sda_o = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.st <= HLC_IDLE;
      state_reg.scl_q <= 1'b1;
      state_reg.sda_q <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_sda_o = state_reg.sda_o;
  assign o_sda_oe = state_reg.sda_oe;
  assign o_full_scale_ref = state_reg.full_scale_ref;
  assign o_drive_out = state_reg.drive_out;
  assign o_audio_drive = state_reg.audio_drive;
  assign o_audio_active = state_reg.audio_active;
  assign o_comp_coeff = state_reg.comp_coeff;
  assign o_cal_nominal = state_reg.cal_nominal;
  assign o_fb_level = state_reg.fb_level;
  assign o_audio_full_scale = state_reg.audio_full_scale;
endmodule
`default_nettype wire

// file: hlc_checker.sv
// port assertions for the level register bank
`timescale 1ns/1ns
`default_nettype none
module hlc_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda_oe,
  input wire logic i_closed_loop,
  input wire logic i_overdrive,
  input wire logic [7:0] i_drive_request,
  input wire logic i_cal_store,
  input wire logic [7:0] i_cal_comp,
  input wire logic [7:0] i_cal_feedback,
  input wire logic [7:0] o_full_scale_ref,
  input wire logic [7:0] o_drive_out,
  input wire logic [7:0] o_audio_drive,
  input wire logic o_audio_active,
  input wire logic [8:0] o_comp_coeff,
  input wire logic [7:0] o_cal_nominal,
  input wire logic [7:0] o_fb_level
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  property p_ref_closed;
    $past(i_closed_loop) |-> o_full_scale_ref == o_cal_nominal;
  endproperty
  a_ref_closed: assert property (p_ref_closed) else $error("closed reference wrong");
  property p_nom;
    $past(i_closed_loop) && !$past(i_overdrive) |->
      o_drive_out == (($past(i_drive_request) < o_cal_nominal) ? $past(i_drive_request) : o_cal_nominal);
  endproperty
  a_nom: assert property (p_nom) else $error("closed drive limit wrong");
  property p_open;
    !$past(i_closed_loop) |->
      o_drive_out == (($past(i_drive_request) < o_full_scale_ref) ? $past(i_drive_request) : o_full_scale_ref);
  endproperty
  a_open: assert property (p_open) else $error("open drive limit wrong");
  property p_boost;
    $past(i_closed_loop) && $past(i_overdrive) |-> o_drive_out <= $past(i_drive_request);
  endproperty
  a_boost: assert property (p_boost) else $error("overdrive above request");
  property p_quiet;
    !o_audio_active |-> o_audio_drive == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("audio drive while idle");
  property p_coeff;
    !$past(i_rst) |-> o_comp_coeff >= 9'h0FF && o_comp_coeff <= 9'h1FE;
  endproperty
  a_coeff: assert property (p_coeff) else $error("coefficient out of range");
  property p_comp_store;
    i_cal_store |-> ##2 o_comp_coeff == 9'h0FF + {1'b0, $past(i_cal_comp, 2)};
  endproperty
  a_comp_store: assert property (p_comp_store) else $error("compensation not stored");
  property p_fb_store;
    i_cal_store |-> ##2 o_fb_level == $past(i_cal_feedback, 2);
  endproperty
  a_fb_store: assert property (p_fb_store) else $error("feedback not stored");
  property p_oe_timing;
    $changed(o_sda_oe) |-> !$past(i_scl) && $past(i_scl, 2);
  endproperty
  a_oe_timing: assert property (p_oe_timing) else $error("data enable off clock fall");
endmodule
bind hlc_level_regs hlc_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
  .i_closed_loop(i_closed_loop), .i_overdrive(i_overdrive), .i_drive_request(i_drive_request),
  .i_cal_store(i_cal_store), .i_cal_comp(i_cal_comp), .i_cal_feedback(i_cal_feedback),
  .o_full_scale_ref(o_full_scale_ref), .o_drive_out(o_drive_out), .o_audio_drive(o_audio_drive),
  .o_audio_active(o_audio_active), .o_comp_coeff(o_comp_coeff), .o_cal_nominal(o_cal_nominal),
  .o_fb_level(o_fb_level));
`default_nettype wire

// file: hlc_host_model.sv
// two-wire host model driving serial clock and data
`timescale 1ns/1ns
`default_nettype none
module hlc_host_model (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_scl,
  output logic o_sda
);
  // released lines read high through the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hp;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic start;
    o_sda = 1'b1;
    hp;
    o_scl = 1'b1;
    hp;
    o_sda = 1'b0;
    hp;
    o_scl = 1'b0;
    hp;
  endtask
  task automatic stop;
    o_sda = 1'b0;
    hp;
    o_scl = 1'b1;
    hp;
    o_sda = 1'b1;
    hp;
  endtask
  // data changes only while the clock is low
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    hp;
    o_scl = 1'b1;
    hp;
    r = i_line;
    o_scl = 1'b0;
    hp;
  endtask
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      v[i] = r;
    end
    bitx(last, r);
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the level register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_clk, scl, h_sda, line, oe, sda_o, act, k;
  logic i_rst = 1'b1, cl = 1'b0, od = 1'b0, st = 1'b0;
  logic [7:0] req = 8'h00, lvl = 8'h00, cc = 8'h00, cf = 8'h00;
  logic [7:0] fsr, drv, adr, nom, fbl, afs, d, lm;
  logic [8:0] cof;
  logic [7:0] sh [8];
  logic [7:0] corner [7] = '{8'h1F, 8'h20, 8'h2F, 8'h50, 8'hBF, 8'hC0, 8'hFF};
  int err_count = 0, samples_checked = 0, cyc = 0;
  assign line = h_sda & ~oe;
  hlc_level_regs DUT (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(line), .o_sda_o(sda_o), .o_sda_oe(oe),
    .i_closed_loop(cl), .i_overdrive(od), .i_drive_request(req), .i_audio_level(lvl), .i_cal_store(st),
    .i_cal_comp(cc), .i_cal_feedback(cf), .o_full_scale_ref(fsr), .o_drive_out(drv), .o_audio_drive(adr),
    .o_audio_active(act), .o_comp_coeff(cof), .o_cal_nominal(nom), .o_fb_level(fbl), .o_audio_full_scale(afs));
  hlc_host_model host (.i_clk(i_clk), .i_line(line), .o_scl(scl), .o_sda(h_sda));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic chk_wide(input logic [8:0] g, input logic [8:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
    chk_wide({1'b0, g}, {1'b0, e});
  endtask
  task automatic chk_ack(input logic g, input logic e);
    chk_wide({8'h00, g}, {8'h00, e});
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic k0, k1, k2;
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT, 1'b0}, k0);
    host.tx(a, k1);
    host.tx(v, k2);
    host.stop;
    chk_ack(k0 & k1 & k2, 1'b1);
    if (a inside {[8'h12:8'h19]}) sh[a - 8'h12] = v;
  endtask
  task automatic rd(input logic [7:0] a);
    logic k0, k1, k2;
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT, 1'b0}, k0);
    host.tx(a, k1);
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT, 1'b1}, k2);
    host.rx(1'b1, d);
    host.stop;
    chk_ack(k0 & k1 & k2, 1'b1);
    chk_data(d, (a inside {[8'h12:8'h19]}) ? sh[a - 8'h12] : 8'h00);
  endtask
  // two-byte burst read, host acks the first byte
  task automatic rd_pair(input logic [7:0] a);
    logic k0, k1, k2;
    logic [7:0] d2;
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT, 1'b0}, k0);
    host.tx(a, k1);
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT, 1'b1}, k2);
    host.rx(1'b0, d);
    host.rx(1'b1, d2);
    host.stop;
    chk_ack(k0 & k1 & k2, 1'b1);
    chk_data(d, sh[a - 8'h12]);
    chk_data(d2, sh[a - 8'h11]);
  endtask
  // two-byte burst write, pointer advances
  task automatic wr2(input logic [7:0] a, input logic [7:0] v0, input logic [7:0] v1);
    logic k0, k1, k2, k3;
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT, 1'b0}, k0);
    host.tx(a, k1);
    host.tx(v0, k2);
    host.tx(v1, k3);
    host.stop;
    chk_ack(k0 & k1 & k2 & k3, 1'b1);
    sh[a - 8'h12] = v0;
    sh[a - 8'h11] = v1;
  endtask
  function automatic logic [7:0] exp_audio(input logic [7:0] v);
    logic [7:0] r;
    r = (v >= sh[1]) ? sh[3] : v;
    if (r < sh[2]) r = sh[2];
    if (r > sh[3]) r = sh[3];
    return (v < sh[0]) ? 8'h00 : r;
  endfunction
  initial begin
    void'($urandom(32'h8db1));
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    for (int i = 0; i < 8; i++) sh[i] = hlc_pkg::RST_ALL[i*8 +: 8];
    for (int i = 0; i < 8; i++) rd(8'h12 + 8'(i));
    chk_data(nom, 8'h3E);
    chk_data(afs, 8'hFF);
    chk_data(fbl, 8'h6F);
    chk_wide(cof, 9'h10B);
    rd_pair(8'h16);
    chk_ack(sda_o, 1'b0);
    wr(8'h20, 8'h5A);
    rd(8'h20);
    rd(8'h11);
    host.start;
    host.tx({hlc_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, k);
    host.stop;
    chk_ack(k, 1'b0);
    for (int i = 0; i < 8; i++) wr(8'h12 + 8'(i), 8'($urandom));
    wr2(8'h14, 8'($urandom), 8'($urandom));
    for (int i = 0; i < 8; i++) rd(8'h12 + 8'(i));
    wr(8'h16, 8'($urandom));
    cc = 8'($urandom);
    cf = 8'($urandom);
    st = 1'b1;
    @(negedge i_clk);
    st = 1'b0;
    sh[6] = cc;
    sh[7] = cf;
    @(negedge i_clk);
    chk_wide(cof, 9'h0FF + {1'b0, cc});
    chk_data(fbl, cf);
    chk_data(nom, sh[4]);
    rd(8'h18);
    rd(8'h19);
    wr(8'h12, 8'h20);
    wr(8'h13, 8'hC0);
    wr(8'h14, 8'h30);
    wr(8'h15, 8'hA0);
    chk_data(afs, 8'hC0);
    for (int i = 0; i < 27; i++) begin
      lvl = (i < 7) ? corner[i] : 8'($urandom);
      repeat (2) @(negedge i_clk);
      chk_data(adr, exp_audio(lvl));
      chk_ack(act, lvl >= sh[0]);
    end
    for (int i = 0; i < 40; i++) begin
      {cl, od} = 2'($urandom);
      req = (i < 2) ? {8{i[0]}} : 8'($urandom);
      lm = (cl && !od) ? sh[4] : sh[5];
      repeat (2) @(negedge i_clk);
      chk_data(fsr, cl ? sh[4] : sh[5]);
      chk_data(drv, (req < lm) ? req : lm);
    end
    stop_test;
  end
endmodule
`default_nettype wire
